// ---- design/idc_pkg.sv ----
// Purpose: shared constants and types for the input ddr capture register
// Assumes: one 50 MHz system clock, word access over ahb-lite
// Notes:   offsets are byte addresses on the register bus
package idc_pkg;

    // bus shape
    localparam int unsigned BUS_W      = 32;
    localparam int unsigned OFF_W      = 8;
    localparam logic [2:0]  HSIZE_WORD = 3'h2;

    // register offsets
    localparam logic [OFF_W-1:0] CTRL_OFF = 8'h00;
    localparam logic [OFF_W-1:0] STAT_OFF = 8'h04;
    localparam logic [OFF_W-1:0] SDR_OFF  = 8'h08;

    // control register fields
    localparam int unsigned CTRL_W       = 8;
    localparam int unsigned MODE_LSB     = 0;
    localparam int unsigned CLK_INV_BIT  = 2;
    localparam int unsigned CLKN_INV_BIT = 3;
    localparam int unsigned DIN_INV_BIT  = 4;
    localparam int unsigned RUN_BIT      = 5;
    localparam int unsigned HOLD_BIT     = 6;
    localparam int unsigned TIME_BIT     = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

    // single-rate flip-flop control fields
    localparam int unsigned SDR_W      = 4;
    localparam int unsigned KIND_LSB   = 0;
    localparam int unsigned SDR_CE_BIT = 2;
    localparam int unsigned SDR_SR_BIT = 3;
    localparam logic [SDR_W-1:0] SDR_RST = 4'h0;

    // status register fields
    localparam int unsigned STAT_W        = 8;
    localparam int unsigned ST_RISE_BIT   = 0;
    localparam int unsigned ST_FALL_BIT   = 1;
    localparam int unsigned ST_DONE_BIT   = 2;
    localparam int unsigned ST_BUSY_BIT   = 3;
    localparam int unsigned ST_DINERR_BIT = 4;
    localparam int unsigned ST_PAIROK_BIT = 5;
    localparam int unsigned ST_SDR_BIT    = 6;
    localparam int unsigned ST_CLK_BIT    = 7;

    // output alignment modes
    typedef enum logic [1:0] {
        split_edge_mode,
        same_edge_mode,
        rise_aligned_piped_mode
    } idc_mode_t;

    // single-rate flip-flop variants
    typedef enum logic [1:0] {
        ff_ce_async_clear,
        ff_ce_async_preset,
        ff_ce_sync_reset,
        ff_ce_sync_set
    } idc_ff_kind_t;

    // field to mode, the spare code falls back to the default mode
    function automatic idc_mode_t decode_mode(input logic [1:0] f);
        unique case (f)
            2'h1:    decode_mode = same_edge_mode;
            2'h2:    decode_mode = rise_aligned_piped_mode;
            default: decode_mode = split_edge_mode;
        endcase
    endfunction

endpackage

// ---- design/idc_sdr_ff.sv ----
// Purpose: single-rate bit-slice flip-flop with selectable clear/set style
// Assumes: tick is the capture rising-edge enable of the parent
// Notes:   asynchronous styles act at the next system edge, ignoring tick
`timescale 1ns/1ps
`default_nettype none
module idc_sdr_ff (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // configuration
    input  wire idc_pkg::idc_ff_kind_t kind,
    input  wire logic                  ce,
    input  wire logic                  ctl,
    // data
    input  wire logic                  tick,
    input  wire logic                  d,
    output logic                       q
);
    import idc_pkg::*;

    logic next_q;

    // style decode
    wire is_async  = (kind == ff_ce_async_clear) || (kind == ff_ce_async_preset);
    wire force_val = (kind == ff_ce_async_preset) || (kind == ff_ce_sync_set);

    // clear/set beats enable; sync styles wait for the capture edge
    always_comb begin
        next_q = q;
        if (ctl && is_async) begin
            next_q = force_val;
        end else if (tick) begin
            if (ctl) begin
                next_q = force_val;
            end else if (ce) begin
                next_q = d;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= 1'h0;
        end else begin
            q <= next_q;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    async_force_a: assert property (ctl && is_async |=> q == $past(force_val))
        else $error("async clear/preset did not force the output");
    sync_wait_a: assert property (ctl && !is_async && !tick |=> $stable(q))
        else $error("sync reset/set acted off the capture edge");
    ce_load_a: assert property (tick && !ctl && ce |=> q == $past(d))
        else $error("enabled flip-flop did not load data");
    sdr_load_c: cover property (tick && ce && !ctl ##2 tick && ctl);

endmodule // idc_sdr_ff
`default_nettype wire

// ---- design/idc_capture_top.sv ----
// Purpose: input ddr capture register of one bit slice, with ahb-lite control
// Assumes: one 50 MHz clock; capture clock is sys_clk/2 made by a phase toggle
// Notes:   rise/fall samples are taken on alternate system edges of a capture period
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - three output alignment modes are chosen by a static control field.
// - split-edge mode updates the rise output at the rising edge and the fall output at the falling edge.
// - same-edge mode changes both outputs on the rising edge, pairing the new rise sample with the previous fall.
// - pipelined mode presents both samples of one period together on the rising edge.
// - a single-rate flip-flop offers async clear, async preset, sync reset or sync set, with clock enable.
// - in time mode the slice is held for calibration until the delay controller reports ready.
// - reset clears the capture register at once and its release waits for a capture rising edge.
// - the alignment mode defaults to split-edge.
// - setting the clock inversion option makes the register use the inverted capture clock.
module idc_capture_top (
    // system
    input  wire logic                        sys_clk,
    input  wire logic                        nrst,
    // ahb-lite slave
    input  wire logic                        hsel,
    input  wire logic [idc_pkg::BUS_W-1:0]   haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [idc_pkg::BUS_W-1:0]   hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic [idc_pkg::BUS_W-1:0]        hrdata,
    output logic                             hresp,
    // pad and delay controller
    input  wire logic                        din,
    input  wire logic                        delay_ready,
    // capture clock pair
    output logic                             capture_clk,
    output logic                             capture_clk_n,
    // fabric side
    output logic                             rise_sample_out,
    output logic                             fall_sample_out,
    output logic                             sdr_sample_out,
    output logic                             cal_busy
);
    import idc_pkg::*;

    logic [CTRL_W-1:0] ctrl;
    logic [SDR_W-1:0]  sdr_ctrl;
    logic [OFF_W-1:0]  bus_addr;
    logic              wr_pend;
    logic              wr_word;
    logic              rd_pend;
    logic              cap_rst;
    logic              rise_hold;
    logic              fall_hold;
    logic              next_rise;
    logic              next_fall;
    logic [STAT_W-1:0] status;
    idc_mode_t         mode;

    // bus decode
    wire                ahb_sel  = hsel && hready && htrans[1];
    wire                ctrl_hit = (bus_addr == CTRL_OFF);
    wire                stat_hit = (bus_addr == STAT_OFF);
    wire                sdr_hit  = (bus_addr == SDR_OFF);
    wire [BUS_W-1:0]    rd_mux   = ctrl_hit ? {{(BUS_W-CTRL_W){1'b0}}, ctrl}
                                 : stat_hit ? {{(BUS_W-STAT_W){1'b0}}, status}
                                 : sdr_hit  ? {{(BUS_W-SDR_W){1'b0}}, sdr_ctrl}
                                 : 32'h0000_0000;

    // capture timing; inversion moves the used edge to the falling one
    assign mode        = decode_mode(ctrl[MODE_LSB +: 2]);
    wire   clk_inv     = ctrl[CLK_INV_BIT];
    wire   clkn_inv    = ctrl[CLKN_INV_BIT];
    wire   hold        = ctrl[HOLD_BIT];
    wire   run         = ctrl[RUN_BIT] && !cal_busy;
    wire   rise_tick   = run && (capture_clk == clk_inv);
    wire   fall_tick   = run && (capture_clk != clk_inv);
    wire   next_clk    = run ? !capture_clk : capture_clk;
    wire   clr_out     = hold || cap_rst || cal_busy;
    wire   din_inv_err = ctrl[DIN_INV_BIT];
    wire   pair_ok     = !clkn_inv;

    // status word; din inversion is never applied, only flagged
    always_comb begin
        status                = '0;
        status[ST_RISE_BIT]   = rise_sample_out;
        status[ST_FALL_BIT]   = fall_sample_out;
        status[ST_DONE_BIT]   = ctrl[TIME_BIT] && !cal_busy;
        status[ST_BUSY_BIT]   = cal_busy;
        status[ST_DINERR_BIT] = din_inv_err;
        status[ST_PAIROK_BIT] = pair_ok;
        status[ST_SDR_BIT]    = sdr_sample_out;
        status[ST_CLK_BIT]    = capture_clk;
    end

    // ahb-lite: writes zero-wait, reads take one wait state so a write just ahead is seen
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            hreadyout <= 1'h1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'h0;
            wr_pend   <= 1'h0;
            wr_word   <= 1'h0;
            rd_pend   <= 1'h0;
            bus_addr  <= 8'h00;
        end else begin
            hresp     <= 1'h0;
            wr_pend   <= ahb_sel && hwrite;
            wr_word   <= hsize == HSIZE_WORD;
            rd_pend   <= ahb_sel && !hwrite;
            hreadyout <= !(ahb_sel && !hwrite);
            if (ahb_sel) begin
                bus_addr <= haddr[OFF_W-1:0];
            end
            if (rd_pend) begin
                hrdata <= rd_mux;
            end
        end
    end

    // software registers; unmapped or narrow writes are dropped
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrl     <= CTRL_RST;
            sdr_ctrl <= SDR_RST;
        end else if (wr_pend && wr_word) begin
            if (ctrl_hit) begin
                ctrl <= hwdata[CTRL_W-1:0];
            end
            if (sdr_hit) begin
                sdr_ctrl <= hwdata[SDR_W-1:0];
            end
        end
    end

    // capture clock pair and calibration hold, all from flops
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            capture_clk   <= 1'h0;
            capture_clk_n <= 1'h1;
            cal_busy      <= 1'h0;
        end else begin
            capture_clk   <= next_clk;
            capture_clk_n <= clkn_inv ? next_clk : !next_clk;
            cal_busy      <= ctrl[TIME_BIT] && !delay_ready;
        end
    end

    // hold clears at once, release only on a capture rising edge
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cap_rst <= 1'h1;
        end else if (hold) begin
            cap_rst <= 1'h1;
        end else if (rise_tick) begin
            cap_rst <= 1'h0;
        end
    end

    // per-edge sample stages feeding the same-edge modes
    always_ff @(posedge sys_clk) begin
        if (!nrst || clr_out) begin
            rise_hold <= 1'h0;
            fall_hold <= 1'h0;
        end else begin
            if (rise_tick) begin
                rise_hold <= din;
            end
            if (fall_tick) begin
                fall_hold <= din;
            end
        end
    end

    // output alignment per mode
    always_comb begin
        next_rise = rise_sample_out;
        next_fall = fall_sample_out;
        if (clr_out) begin
            next_rise = 1'h0;
            next_fall = 1'h0;
        end else begin
            unique case (mode)
                split_edge_mode: begin
                    if (rise_tick) begin
                        next_rise = din;
                    end
                    if (fall_tick) begin
                        next_fall = din;
                    end
                end
                same_edge_mode: begin
                    if (rise_tick) begin
                        next_rise = din;
                        next_fall = fall_hold;
                    end
                end
                rise_aligned_piped_mode: begin
                    if (rise_tick) begin
                        next_rise = rise_hold;
                        next_fall = fall_hold;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rise_sample_out <= 1'h0;
            fall_sample_out <= 1'h0;
        end else begin
            rise_sample_out <= next_rise;
            fall_sample_out <= next_fall;
        end
    end

    // single-rate slice flip-flop, clocked by the same capture edge
    idc_sdr_ff u_sdr_ff (
        .clk  (sys_clk),
        .nrst (nrst),
        .kind (idc_ff_kind_t'(sdr_ctrl[KIND_LSB +: 2])),
        .ce   (sdr_ctrl[SDR_CE_BIT]),
        .ctl  (sdr_ctrl[SDR_SR_BIT]),
        .tick (rise_tick),
        .d    (din),
        .q    (sdr_sample_out)
    );

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    split_rise_a: assert property (mode == split_edge_mode && rise_tick && !clr_out |=> rise_sample_out == $past(din))
        else $error("split-edge rise output missed its sample");
    split_fall_a: assert property (mode == split_edge_mode && fall_tick && !clr_out |=> fall_sample_out == $past(din))
        else $error("split-edge fall output missed its sample");
    split_keep_a: assert property (mode == split_edge_mode && rise_tick && !clr_out |=> $stable(fall_sample_out))
        else $error("split-edge fall output moved on a rising tick");
    split_hold_a: assert property (mode == split_edge_mode && fall_tick && !clr_out |=> $stable(rise_sample_out))
        else $error("split-edge rise output moved on a falling tick");
    same_pair_a: assert property (mode == same_edge_mode && rise_tick && !clr_out
                                  |=> rise_sample_out == $past(din) && fall_sample_out == $past(fall_hold))
        else $error("same-edge pair is wrong");
    same_steady_a: assert property (mode != split_edge_mode && !rise_tick && !clr_out
                                    |=> $stable(rise_sample_out) && $stable(fall_sample_out))
        else $error("same-edge output changed off the rising edge");
    piped_pair_a: assert property (mode == rise_aligned_piped_mode && rise_tick && !clr_out
                                   |=> fall_sample_out == $past(fall_hold) && rise_sample_out == $past(rise_hold))
        else $error("pipelined pair is wrong");
    piped_latency_a: assert property (mode == rise_aligned_piped_mode && rise_tick && !clr_out && $past(rise_tick, 2)
                                      && !$past(clr_out) && !$past(clr_out, 2)
                                      |=> rise_sample_out == $past(din, 3))
        else $error("pipelined rise output latency is wrong");
    // clears and gating; the release may follow one cycle after hold drops, so only the first edge is pinned
    hold_clear_a: assert property (hold |=> !rise_sample_out && !fall_sample_out && cap_rst)
        else $error("hold did not clear the outputs");
    cap_release_a: assert property ($fell(cap_rst) |-> $past(rise_tick) && !$past(hold))
        else $error("capture reset released off a rising tick");
    stage_clear_a: assert property (clr_out |=> !rise_hold && !fall_hold)
        else $error("pipeline stages survived a clear");
    cal_gate_a: assert property (cal_busy |=> !rise_sample_out && !fall_sample_out && $stable(capture_clk))
        else $error("capture ran during calibration");
    inv_edge_a: assert property (mode == split_edge_mode && run && clk_inv && capture_clk && !clr_out
                                 |=> rise_sample_out == $past(din))
        else $error("inverted clock uses the wrong edge");
    inv_fall_a: assert property (mode == split_edge_mode && run && clk_inv && !capture_clk && !clr_out
                                 |=> fall_sample_out == $past(din))
        else $error("inverted clock loads the fall output on the wrong edge");
    reset_zero_a: assert property (disable iff (1'b0) !nrst |=> !rise_sample_out && !fall_sample_out
                                   && !rise_hold && !fall_hold && mode == split_edge_mode)
        else $error("reset left state behind");

    // bus answers: one wait state per read, writes land at the end of their data phase
    read_wait_a: assert property (ahb_sel && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");
    ctrl_write_a: assert property (wr_pend && wr_word && ctrl_hit |=> ctrl == $past(hwdata[CTRL_W-1:0]))
        else $error("control write did not land");
    okay_resp_a: assert property (!hresp)
        else $error("slave answered with an error response");

    // complementary output follows the option one edge later, as the clock flop does
    pair_inv_a: assert property (!clkn_inv |=> capture_clk_n != capture_clk)
        else $error("complementary clock is not inverted");
    pair_same_a: assert property (clkn_inv |=> capture_clk_n == capture_clk)
        else $error("complementary clock does not follow the true clock");

    // calibration gate trails the controller ready by one flop
    cal_hold_a: assert property (ctrl[TIME_BIT] && !delay_ready |=> cal_busy)
        else $error("slice not held during calibration");
    cal_done_a: assert property (delay_ready || !ctrl[TIME_BIT] |=> !cal_busy)
        else $error("slice still held after calibration finished");

    split_run_c: cover property (mode == split_edge_mode && rise_tick ##1 fall_tick ##1 rise_tick);
    same_run_c: cover property (mode == same_edge_mode && rise_tick && !clr_out ##2 rise_tick);
    piped_run_c: cover property (mode == rise_aligned_piped_mode && rise_tick && !clr_out ##2 rise_tick);
    cal_end_c: cover property (cal_busy ##1 !cal_busy);

endmodule // idc_capture_top
`default_nettype wire

// ---- tb/idc_ddr_source.sv ----
// Purpose: far-side source launching ddr data onto the pad
// Assumes: one bit launched per capture half period, i.e. every sys_clk rising edge
// Notes:   keeps changing outside frames so a stale pad value never passes
`timescale 1ns/1ps
`default_nettype none
module idc_ddr_source (
    // clocks seen from the far side
    input  wire logic sys_clk,
    input  wire logic capture_clk,
    input  wire logic capture_clk_n,
    // pad and pair flag
    output logic      din,
    output logic      pair_inv
);
    logic [7:0] lfsr;

    // complementary pair as the far side sees it
    assign pair_inv = capture_clk ^ capture_clk_n;

    // new bit each half period; an lfsr avoids long flat runs that hide slips
    always @(posedge sys_clk) begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        din  <= lfsr[7];
    end

    // known starting pattern
    initial begin
        lfsr = 8'h5a;
        din  = 1'b0;
    end
endmodule // idc_ddr_source
`default_nettype wire

// ---- tb/idc_capture_top_tb.sv ----
// Purpose: self-checking bench for the input ddr capture register
// Assumes: one 50 MHz clock, single-word ahb-lite master
// Notes:   a negedge scoreboard compares outputs with the pad history
`timescale 1ns/1ps
`default_nettype none
module idc_capture_top_tb;
    import idc_pkg::*;
    logic        sys_clk, nrst, hsel, hwrite, hreadyout, hresp, din, delay_ready, pair_inv;
    logic        capture_clk, capture_clk_n, rise_sample_out, fall_sample_out, sdr_sample_out, cal_busy;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic        sb_on, sdr_on, inv, ninv, pr, pf, cs;
    logic [3:0]  ch, dh;
    logic [1:0]  k;
    idc_mode_t   mode;
    int          warm, n_mismatch, samples_checked;
    idc_mode_t   tmode [5] = '{split_edge_mode, same_edge_mode, rise_aligned_piped_mode,
                               split_edge_mode, rise_aligned_piped_mode};
    logic        tinv [5]  = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    // 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    idc_capture_top uut (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .din(din), .delay_ready(delay_ready), .capture_clk(capture_clk),
        .capture_clk_n(capture_clk_n), .rise_sample_out(rise_sample_out),
        .fall_sample_out(fall_sample_out), .sdr_sample_out(sdr_sample_out), .cal_busy(cal_busy));

    idc_ddr_source src (.sys_clk(sys_clk), .capture_clk(capture_clk), .capture_clk_n(capture_clk_n),
        .din(din), .pair_inv(pair_inv));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one single word transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        hsize  <= HSIZE_WORD;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
        ahb(1'b0, a, 32'h0);
        chk(rd & m, e, w);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // scoreboard: index 0 is this cycle, a rise tick is a cycle with capture_clk == inv
    always @(negedge sys_clk) begin
        ch = {ch[2:0], capture_clk};
        dh = {dh[2:0], din};
        warm = sb_on ? warm + 1 : 0;
        if (warm > 2) chk(pair_inv, !ninv, "clock pair");
        if (warm > 10) begin
            chk(ch[0] ^ ch[1], 1'b1, "capture clock toggles");
            if (ch[1] == inv && ch[0] != inv) begin
                if (mode == rise_aligned_piped_mode) chk(rise_sample_out, dh[3], "piped rise");
                else chk(rise_sample_out, dh[1], "rise sample");
                if (mode != split_edge_mode) chk(fall_sample_out, dh[2], "paired fall");
                if (sdr_on) chk(sdr_sample_out, dh[1], "sdr load");
            end else if (mode == split_edge_mode) chk(fall_sample_out, dh[1], "fall sample");
            else chk({rise_sample_out, fall_sample_out}, {pr, pf}, "steady off rise");
        end
        pr = rise_sample_out;
        pf = fall_sample_out;
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (6000) @(posedge sys_clk);
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end

    initial begin
        {sys_clk, nrst, hsel, hwrite, delay_ready, sb_on, sdr_on, inv, ninv} = '0;
        {htrans, haddr, hwdata, ch, dh, warm, n_mismatch, samples_checked} = '0;
        hsize = HSIZE_WORD;
        mode = split_edge_mode;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        chk({rise_sample_out, fall_sample_out, sdr_sample_out, cal_busy}, 4'h0, "reset outputs");
        chk({capture_clk, capture_clk_n, hreadyout, hresp}, 4'h6, "reset clock and bus");
        rdc(CTRL_OFF, 32'hffffffff, 32'h0, "ctrl default");
        rdc(SDR_OFF, 32'hffffffff, 32'h0, "sdr default");
        ahb(1'b1, 8'h0c, 32'hff);
        rdc(8'h0c, 32'hffffffff, 32'h0, "unmapped");
        rdc(STAT_OFF, 32'h33, 32'h20, "status idle");
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            ahb(1'b1, CTRL_OFF, 32'h40 | {29'h0, tinv[i], tmode[i]});
            ahb(1'b1, CTRL_OFF, 32'h20 | {29'h0, tinv[i], tmode[i]});
            mode = tmode[i];
            inv = tinv[i];
            sb_on = 1'b1;
            repeat (40) @(posedge sys_clk);
            sb_on = 1'b0;
            ahb(1'b1, CTRL_OFF, 32'h60 | {29'h0, tinv[i], tmode[i]});
            repeat (2) @(posedge sys_clk);
            chk({rise_sample_out, fall_sample_out}, 2'h0, "hold clears");
            cs = capture_clk;
            repeat (3) @(posedge sys_clk);
            chk(capture_clk, !cs, "clock runs in hold");
            $display("test mode %0d inv %0d done", tmode[i], tinv[i]);
        end
        // complementary clock inversion option
        inv = 1'b0;
        mode = split_edge_mode;
        ahb(1'b1, CTRL_OFF, 32'h40);
        ahb(1'b1, CTRL_OFF, 32'h28);
        ninv = 1'b1;
        sb_on = 1'b1;
        repeat (30) @(posedge sys_clk);
        sb_on = 1'b0;
        rdc(STAT_OFF, 32'h20, 32'h0, "pair flag");
        $display("test clock pair done");
        // time-mode calibration gates the slice until delay_ready
        ahb(1'b1, CTRL_OFF, 32'h40);
        ninv = 1'b0;
        ahb(1'b1, CTRL_OFF, 32'ha0);
        repeat (3) @(posedge sys_clk);
        cs = capture_clk;
        repeat (2) @(posedge sys_clk);
        chk({cal_busy, rise_sample_out, fall_sample_out, capture_clk}, {3'h4, cs}, "slice held");
        rdc(STAT_OFF, 32'h08, 32'h08, "busy flag");
        delay_ready <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(cal_busy, 1'b0, "calibration over");
        sb_on = 1'b1;
        repeat (30) @(posedge sys_clk);
        sb_on = 1'b0;
        rdc(STAT_OFF, 32'h0c, 32'h04, "done flag");
        $display("test calibration done");
        // single-rate kinds in order 1,0,3,2 so each forced value differs
        for (int j = 0; j < 4; j++) begin
            k = 2'(j ^ 1);
            ahb(1'b1, SDR_OFF, {28'h0, 2'h2, k});
            repeat (4) @(posedge sys_clk);
            chk(sdr_sample_out, k[0], "forced value");
        end
        ahb(1'b1, SDR_OFF, 32'h4);
        sdr_on = 1'b1;
        sb_on = 1'b1;
        repeat (30) @(posedge sys_clk);
        sb_on = 1'b0;
        sdr_on = 1'b0;
        $display("test single rate done");
        // second reset in mid-run, while capturing
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({rise_sample_out, fall_sample_out, sdr_sample_out, capture_clk, cal_busy}, 5'h00, "mid-run reset");
        nrst <= 1'b1;
        @(posedge sys_clk);
        rdc(CTRL_OFF, 32'hffffffff, 32'h0, "ctrl after reset");
        $display("test mid-run reset done");
        close_out();
    end
endmodule // idc_capture_top_tb
`default_nettype wire
